//--- include/irq3_pkg.sv
// package for the third external interrupt block: register map, fields, counts
// assumes a 100 MHz system clock and a plain address/strobe register port
package irq3_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'h9A;
	localparam logic [7:0] MODE_ADDR = 8'h9B;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	// control register fields
	localparam int RUN_BIT = 0;
	localparam int SRC_LSB = 1;
	localparam int EDGE_LSB = 3;
	localparam int TIMING_BIT = 6;
	localparam int IRQSRC_BIT = 7;
	// mode register fields
	localparam int FILT_LSB = 0;
	localparam int RELOAD_BIT = 2;
	localparam int CMPSEL_BIT = 3;
	localparam int CMP0_LSB = 4;
	localparam int CMP1_LSB = 6;
	// extra status/data registers
	localparam logic [7:0] STAT_ADDR = 8'hA0;
	localparam logic [7:0] CMP0_ADDR = 8'hA1;
	localparam logic [7:0] CMP1_ADDR = 8'hA2;
	localparam logic [7:0] COUNT_ADDR = 8'hA3;
	localparam int STAT_FLAG_BIT = 0;
	localparam int STAT_PIN_BIT = 1;
	// clock dividers, filter sample count, counter reset
	localparam logic [4:0] DIV8_LAST = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1F;
	localparam logic [6:0] RING128_HALF = 7'h3F;
	localparam int FILT_SAMPLES = 3;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_BAD} edge_t;
	typedef enum logic [1:0] {CMP_KEEP, CMP_TOGGLE, CMP_LOW, CMP_HIGH} cmp_mode_t;
endpackage

//--- src/irq3_filter.sv
// third external interrupt request generator with glitch filter and timer controls
// assumes pin inputs synchronous to clk; ring clock divided from the ring tick input
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - source field 0 takes pin as request
// - timing bit 0 syncs to count source
// - timing bit 1 unfiltered requests immediately
// - filter needs three agreeing samples
// - filter field picks none, f1, f8, f32
// - filter selected syncs to sampling clock
// - port bit reads unfiltered pin level
// - source 1 sets flag from ring clock
// - polarity rising, falling, both; 11 invalid
// - count source f1, f8, f32, fast ring
// - run bit starts and stops timer
// - field rewrites may spuriously set flag
// - compare mode requests on every event
// - reload clears counter on compare 1
// - select bit picks capture or compare
// - compare 0 drives output per field
// - compare 1 drives output per field
// - acknowledge clears the request flag
module irq3_filter (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire irq3_pkg::reg_req_t req,
	output logic [7:0] rdata,
	// pins and clock ticks
	input wire logic pin_in,
	input wire logic ring_tick,
	input wire logic fast_ring_tick,
	input wire logic irq_ack,
	// outputs
	output logic irq_request_flag,
	output logic compare_output_pin,
	output logic capture_strobe
);
	import irq3_pkg::*;

	function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
		unique case (edge_t'(sel))
			EDGE_RISE: edge_hit = !prev && cur;
			EDGE_FALL: edge_hit = prev && !cur;
			EDGE_BOTH: edge_hit = prev != cur;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	function automatic logic cmp_next(input logic [1:0] m, input logic cur);
		unique case (cmp_mode_t'(m))
			CMP_KEEP: cmp_next = cur;
			CMP_TOGGLE: cmp_next = !cur;
			CMP_LOW: cmp_next = 1'b0;
			CMP_HIGH: cmp_next = 1'b1;
		endcase
	endfunction

	logic [7:0] ctrl_q, ctrl_d, mode_q, mode_d, cmp0_q, cmp0_d, cmp1_q, cmp1_d;
	logic [7:0] rdata_d;
	logic [4:0] div_q, div_d;
	logic [6:0] ring_q, ring_d;
	logic sync1_q, sync2_q, prev_q, prev_d;
	logic [2:0] samp_q, samp_d;
	logic filt_q, filt_d;
	logic pend_q, pend_d;
	logic flag_d, cmp_pin_d, cap_d;
	logic [15:0] count_q, count_d;
	logic tick8, tick32, samp_tick, cnt_tick, filt_on, in_level, ev, ring_ev;
	logic field_write;

	// dividers
	always_comb begin
		div_d = div_q + 5'h01;
		tick8 = div_q[2:0] == DIV8_LAST[2:0];
		tick32 = div_q == DIV32_LAST;
		ring_d = ring_tick ? ring_q + 7'h01 : ring_q;
		// two flag sets per ring period when both edges selected, else one
		ring_ev = ring_tick && ((ring_q == RING128_HALF) ||
			(ctrl_q[EDGE_LSB+:2] == 2'b10 && ring_q == 7'h7F));
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= 5'h00;
			ring_q <= 7'h00;
		end else begin
			div_q <= div_d;
			ring_q <= ring_d;
		end
	end

	// pin synchroniser; first stage feeds only the second
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// filter and event detection
	always_comb begin
		filt_on = mode_q[FILT_LSB+:2] != 2'b00;
		unique case (mode_q[FILT_LSB+:2])
			2'b01: samp_tick = 1'b1;
			2'b10: samp_tick = tick8;
			2'b11: samp_tick = tick32;
			default: samp_tick = 1'b0;
		endcase
		unique case (ctrl_q[SRC_LSB+:2])
			2'b00: cnt_tick = 1'b1;
			2'b01: cnt_tick = tick8;
			2'b10: cnt_tick = tick32;
			default: cnt_tick = fast_ring_tick;
		endcase
		samp_d = samp_tick ? {samp_q[1:0], sync2_q} : samp_q;
		filt_d = filt_q;
		if (samp_tick && samp_d[FILT_SAMPLES-1:0] == {FILT_SAMPLES{samp_d[0]}})
			filt_d = samp_d[0];
		in_level = filt_on ? filt_q : sync2_q;
		prev_d = in_level;
		ev = edge_hit(ctrl_q[EDGE_LSB+:2], prev_q, in_level);
	end

	// request timing and flag
	always_comb begin
		pend_d = pend_q;
		flag_d = irq_request_flag;
		if (!ctrl_q[IRQSRC_BIT]) begin
			if (ev)
				pend_d = 1'b1;
			if (filt_on || ctrl_q[TIMING_BIT] || mode_q[CMPSEL_BIT]) begin
				// filtered edges already align with the sampling tick
				if (pend_d) begin
					flag_d = 1'b1;
					pend_d = 1'b0;
				end
			end else if (pend_d && cnt_tick && ctrl_q[RUN_BIT]) begin
				flag_d = 1'b1;
				pend_d = 1'b0;
			end
		end else if (ring_ev) begin
			flag_d = 1'b1;
		end
		if (field_write)
			pend_d = 1'b0;
		// acknowledge loses against a same-cycle set
		if (irq_ack && !(flag_d && !irq_request_flag))
			flag_d = 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			samp_q <= 3'h0;
			filt_q <= 1'b0;
			prev_q <= 1'b0;
			pend_q <= 1'b0;
			irq_request_flag <= 1'b0;
		end else begin
			samp_q <= samp_d;
			filt_q <= filt_d;
			prev_q <= prev_d;
			pend_q <= pend_d;
			irq_request_flag <= flag_d;
		end
	end

	// capture timer core
	always_comb begin
		count_d = count_q;
		cmp_pin_d = compare_output_pin;
		cap_d = 1'b0;
		if (ctrl_q[RUN_BIT] && cnt_tick) begin
			count_d = count_q + 16'h0001;
			if (mode_q[CMPSEL_BIT]) begin
				if (count_q[7:0] == cmp0_q)
					cmp_pin_d = cmp_next(mode_q[CMP0_LSB+:2], compare_output_pin);
				if (count_q[7:0] == cmp1_q) begin
					cmp_pin_d = cmp_next(mode_q[CMP1_LSB+:2], cmp_pin_d);
					if (mode_q[RELOAD_BIT])
						count_d = COUNT_RESET;
				end
			end
		end
		if (!mode_q[CMPSEL_BIT] && ev && !ctrl_q[IRQSRC_BIT])
			cap_d = 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= COUNT_RESET;
			compare_output_pin <= 1'b0;
			capture_strobe <= 1'b0;
		end else begin
			count_q <= count_d;
			compare_output_pin <= cmp_pin_d;
			capture_strobe <= cap_d;
		end
	end

	// register port
	always_comb begin
		ctrl_d = ctrl_q;
		mode_d = mode_q;
		cmp0_d = cmp0_q;
		cmp1_d = cmp1_q;
		field_write = 1'b0;
		rdata_d = 8'h00;
		if (req.wr) begin
			unique case (req.addr)
				CTRL_ADDR: begin
					ctrl_d = req.wdata;
					field_write = 1'b1;
				end
				MODE_ADDR: mode_d = req.wdata;
				CMP0_ADDR: cmp0_d = req.wdata;
				CMP1_ADDR: cmp1_d = req.wdata;
				default: ;
			endcase
		end
		if (req.rd) begin
			unique case (req.addr)
				CTRL_ADDR: rdata_d = ctrl_q;
				MODE_ADDR: rdata_d = mode_q;
				CMP0_ADDR: rdata_d = cmp0_q;
				CMP1_ADDR: rdata_d = cmp1_q;
				COUNT_ADDR: rdata_d = count_q[7:0];
				STAT_ADDR: begin
					rdata_d[STAT_FLAG_BIT] = irq_request_flag;
					rdata_d[STAT_PIN_BIT] = sync2_q;
				end
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= CTRL_RESET;
			mode_q <= MODE_RESET;
			cmp0_q <= 8'h00;
			cmp1_q <= 8'h00;
			rdata <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			mode_q <= mode_d;
			cmp0_q <= cmp0_d;
			cmp1_q <= cmp1_d;
			rdata <= rdata_d;
		end
	end

	a_ack_clears: assert property (@(posedge clk) disable iff (!reset_n)
		irq_ack && irq_request_flag |=> !irq_request_flag)
		else $error("ack did not clear flag");
	a_flag_holds: assert property (@(posedge clk) disable iff (!reset_n)
		irq_request_flag && !irq_ack |=> irq_request_flag)
		else $error("flag dropped without ack");
	a_immediate_req: assert property (@(posedge clk) disable iff (!reset_n)
		ev && !filt_on && ctrl_q[TIMING_BIT] && !ctrl_q[IRQSRC_BIT] && !field_write && !irq_ack
		|=> irq_request_flag)
		else $error("immediate request missing");
	a_sync_chain: assert property (@(posedge clk) disable iff (!reset_n)
		sync2_q == $past(pin_in, 2))
		else $error("pin synchroniser broken");
	a_run_stopped: assert property (@(posedge clk) disable iff (!reset_n)
		!ctrl_q[RUN_BIT] |=> count_q == $past(count_q))
		else $error("counter moved while stopped");
	a_filter_stable: assert property (@(posedge clk) disable iff (!reset_n)
		filt_q != $past(filt_q) |-> samp_q == {3{filt_q}})
		else $error("filter changed without three samples");
	a_pin_read: assert property (@(posedge clk) disable iff (!reset_n)
		req.rd && req.addr == STAT_ADDR |=> rdata[STAT_PIN_BIT] == $past(sync2_q))
		else $error("port bit not raw level");
	a_reload_zero: assert property (@(posedge clk) disable iff (!reset_n)
		ctrl_q[RUN_BIT] && cnt_tick && mode_q[CMPSEL_BIT] && mode_q[RELOAD_BIT]
		&& count_q[7:0] == cmp1_q && !req.wr |=> count_q == COUNT_RESET)
		else $error("reload failed");
	a_no_filter_none: assert property (@(posedge clk) disable iff (!reset_n)
		mode_q[FILT_LSB+:2] == 2'b00 |-> !samp_tick)
		else $error("sampling without filter");

	// ring source and pin source guards
	a_ring_sets: assert property (@(posedge clk) disable iff (!reset_n)
		ctrl_q[IRQSRC_BIT] && ring_ev && !irq_ack |=> irq_request_flag)
		else $error("ring tick did not set flag");
	a_ring_only: assert property (@(posedge clk) disable iff (!reset_n)
		ctrl_q[IRQSRC_BIT] && !ring_ev && !irq_request_flag |=> !irq_request_flag)
		else $error("pin reached flag under ring source");
	a_sync_wait: assert property (@(posedge clk) disable iff (!reset_n)
		!ctrl_q[IRQSRC_BIT] && !filt_on && !ctrl_q[TIMING_BIT] && !mode_q[CMPSEL_BIT]
		&& !(cnt_tick && ctrl_q[RUN_BIT]) && !irq_request_flag |=> !irq_request_flag)
		else $error("request ahead of count tick");
	a_edge_invalid: assert property (@(posedge clk) disable iff (!reset_n)
		ctrl_q[EDGE_LSB+:2] == 2'b11 |-> !ev)
		else $error("edge seen with invalid polarity");
	a_write_drops: assert property (@(posedge clk) disable iff (!reset_n)
		field_write |=> !pend_q)
		else $error("pending edge kept over rewrite");
	a_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
		irq_ack && !irq_request_flag && flag_d |=> irq_request_flag)
		else $error("ack beat a same-cycle set");

	// filter guards
	a_filt_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!samp_tick |=> filt_q == $past(filt_q))
		else $error("filter moved between samples");
	a_samp_shift: assert property (@(posedge clk) disable iff (!reset_n)
		samp_tick |=> samp_q == {$past(samp_q[1:0]), $past(sync2_q)})
		else $error("sample chain lost a sample");

	// timer and compare output guards
	a_no_reload: assert property (@(posedge clk) disable iff (!reset_n)
		ctrl_q[RUN_BIT] && cnt_tick && !mode_q[RELOAD_BIT]
		|=> count_q == $past(count_q) + 16'h0001)
		else $error("counter skipped a tick");
	a_cmp_stopped: assert property (@(posedge clk) disable iff (!reset_n)
		!ctrl_q[RUN_BIT] |=> compare_output_pin == $past(compare_output_pin))
		else $error("compare output moved while stopped");
	a_cmp_capture: assert property (@(posedge clk) disable iff (!reset_n)
		!mode_q[CMPSEL_BIT] |=> compare_output_pin == $past(compare_output_pin))
		else $error("compare output moved in capture mode");
	a_cmp0_high: assert property (@(posedge clk) disable iff (!reset_n)
		ctrl_q[RUN_BIT] && cnt_tick && mode_q[CMPSEL_BIT] && count_q[7:0] == cmp0_q
		&& count_q[7:0] != cmp1_q && mode_q[CMP0_LSB+:2] == 2'b11 |=> compare_output_pin)
		else $error("compare 0 did not drive high");
	a_cmp1_low: assert property (@(posedge clk) disable iff (!reset_n)
		ctrl_q[RUN_BIT] && cnt_tick && mode_q[CMPSEL_BIT] && count_q[7:0] == cmp1_q
		&& mode_q[CMP1_LSB+:2] == 2'b10 |=> !compare_output_pin)
		else $error("compare 1 did not drive low");
	a_capture_mode: assert property (@(posedge clk) disable iff (!reset_n)
		capture_strobe |-> !$past(mode_q[CMPSEL_BIT]))
		else $error("capture strobe in compare mode");

	// register port guards
	a_ctrl_write: assert property (@(posedge clk) disable iff (!reset_n)
		req.wr && req.addr == CTRL_ADDR |=> ctrl_q == $past(req.wdata))
		else $error("control write lost");
	a_rdata_idle: assert property (@(posedge clk) disable iff (!reset_n)
		!req.rd |=> rdata == 8'h00)
		else $error("read data without read");
	c_flag_set: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq_request_flag));
	c_cmp_toggle: cover property (@(posedge clk) disable iff (!reset_n) $changed(compare_output_pin));
	c_capture: cover property (@(posedge clk) disable iff (!reset_n) capture_strobe);
	c_ring_flag: cover property (@(posedge clk) disable iff (!reset_n)
		ctrl_q[IRQSRC_BIT] && ring_ev);
	c_filter_pass: cover property (@(posedge clk) disable iff (!reset_n) $changed(filt_q));
endmodule

`default_nettype wire

//--- testbench/pin_source.sv
// far-side model: external source driving the shared interrupt pin
// assumes the bench steps the wanted level right after a clock edge
`timescale 1ns/100ps
`default_nettype none
module pin_source (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// wanted level
	input wire logic want,
	// pin
	output logic pin
);
	// push-pull source, so the pin never floats; idle low after reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin <= 1'b0;
		end else begin
			pin <= want;
		end
	end
endmodule
`default_nettype wire

//--- testbench/irq3_filter_test.sv
// self-checking bench for the third external interrupt block
// assumes irq3_pkg and pin_source are compiled first
`timescale 1ns/100ps
`default_nettype none
module irq3_filter_test;
	import irq3_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	reg_req_t req = '0;
	logic [7:0] rdata;
	logic [7:0] d;
	logic want = 1'b0;
	logic ring_tick = 1'b0;
	logic fast_ring_tick = 1'b0;
	logic irq_ack = 1'b0;
	logic pin, flag, cmp_pin, cap;
	int err_count = 0;
	int comparisons = 0;
	int w;
	int c0, c1, n, hi, lo;
	integer seed = 32'hDF17C6F2;
	always #5 clk = ~clk;
	pin_source src (.clk(clk), .reset_n(reset_n), .want(want), .pin(pin));
	irq3_filter dut (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata), .pin_in(pin),
		.ring_tick(ring_tick), .fast_ring_tick(fast_ring_tick), .irq_ack(irq_ack),
		.irq_request_flag(flag), .compare_output_pin(cmp_pin), .capture_strobe(cap));
	task automatic check_bit(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %b", $time, what, got);
		end
	endtask
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h", $time, what, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic set_pin(input logic v);
		@(posedge clk);
		want <= v;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 v = rdata;
	endtask
	// the flag holds once set, so any sighting within the span counts
	task automatic expect_flag(input logic exp, input int span, input string what);
		logic seen;
		seen = 1'b0;
		repeat (span) begin
			@(posedge clk);
			#1 seen = seen | (flag === 1'b1);
		end
		check_bit(seen, exp, what);
	endtask
	task automatic ack;
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		#1 check_bit(flag, 1'b0, "ack clear");
	endtask
	function automatic logic edge_hit(input logic [1:0] pol, input logic rising);
		return (pol == 2'b10) || (pol == 2'b00 && rising) || (pol == 2'b01 && !rising);
	endfunction
	function automatic logic [7:0] ctrl_val(input logic run, input logic [1:0] csrc,
		input logic [1:0] pol, input logic tim, input logic isrc);
		return {isrc, tim, 1'b0, pol, csrc, run};
	endfunction
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		tick(20000);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		final_report();
	end
	initial begin
		tick(12);
		reset_n <= 1'b1;
		reg_rd(CTRL_ADDR, d);
		check_byte(d, CTRL_RESET, "ctrl reset");
		reg_rd(MODE_ADDR, d);
		check_byte(d, MODE_RESET, "mode reset");
		reg_wr(MODE_ADDR, 8'h03);
		reg_rd(MODE_ADDR, d);
		check_byte(d, 8'h03, "mode readback");
		reg_rd(8'h50, d);
		check_byte(d, 8'h00, "unmapped read");
		$display("test registers done");
		reg_wr(MODE_ADDR, 8'h00);
		for (int p = 0; p < 4; p++) begin
			reg_wr(CTRL_ADDR, ctrl_val(1'b0, 2'b00, 2'(p), 1'b1, 1'b0));
			tick(3);
			ack();
			set_pin(1'b1);
			expect_flag(edge_hit(2'(p), 1'b1), 6, "rising edge");
			if (flag === 1'b1) ack();
			set_pin(1'b0);
			expect_flag(edge_hit(2'(p), 1'b0), 6, "falling edge");
			if (flag === 1'b1) ack();
		end
		reg_wr(CTRL_ADDR, ctrl_val(1'b0, 2'b00, EDGE_RISE, 1'b1, 1'b0));
		set_pin(1'b1);
		tick(20);
		check_bit(flag, 1'b1, "flag holds");
		ack();
		set_pin(1'b0);
		$display("test edges done");
		for (int f = 1; f < 4; f++) begin
			reg_wr(MODE_ADDR, 8'(f));
			tick(110);
			ack();
			set_pin(1'b1);
			// pin stays high w+1 cycles; must stay under three f1 samples
			w = $unsigned($random(seed)) % 2;
			tick(w);
			set_pin(1'b0);
			expect_flag(1'b0, 120, "glitch passed");
			set_pin(1'b1);
			tick(3);
			reg_rd(STAT_ADDR, d);
			check_bit(d[STAT_PIN_BIT], 1'b1, "raw pin level");
			expect_flag(1'b1, 120, "filtered edge");
			ack();
			set_pin(1'b0);
		end
		reg_wr(MODE_ADDR, 8'h00);
		tick(110);
		$display("test filter done");
		reg_wr(CTRL_ADDR, ctrl_val(1'b0, 2'b11, EDGE_RISE, 1'b0, 1'b0));
		reg_wr(CTRL_ADDR, ctrl_val(1'b1, 2'b11, EDGE_RISE, 1'b0, 1'b0));
		tick(3);
		ack();
		set_pin(1'b1);
		expect_flag(1'b0, 10, "flag before count tick");
		@(posedge clk);
		fast_ring_tick <= 1'b1;
		@(posedge clk);
		fast_ring_tick <= 1'b0;
		expect_flag(1'b1, 4, "flag on count tick");
		ack();
		set_pin(1'b0);
		$display("test count sync done");
		reg_wr(CTRL_ADDR, ctrl_val(1'b0, 2'b00, EDGE_RISE, 1'b0, 1'b1));
		tick(3);
		ack();
		repeat (130) begin
			@(posedge clk);
			ring_tick <= 1'b1;
			@(posedge clk);
			ring_tick <= 1'b0;
		end
		tick(3);
		check_bit(flag, 1'b1, "ring source flag");
		$display("test ring source done");
		reg_wr(CTRL_ADDR, ctrl_val(1'b0, 2'b11, EDGE_RISE, 1'b0, 1'b0));
		reg_wr(MODE_ADDR, 8'h08);
		tick(3);
		ack();
		set_pin(1'b1);
		expect_flag(1'b1, 6, "compare mode request");
		ack();
		set_pin(1'b0);
		reg_wr(MODE_ADDR, 8'h00);
		tick(4);
		set_pin(1'b1);
		n = 0;
		repeat (8) begin
			@(posedge clk);
			#1 n = n + (cap === 1'b1);
		end
		check_byte(8'(n), 8'h01, "capture strobe");
		set_pin(1'b0);
		c0 = 1 + ($unsigned($random(seed)) % 100);
		c1 = c0 + 1 + ($unsigned($random(seed)) % 50);
		reg_wr(CTRL_ADDR, ctrl_val(1'b0, 2'b00, EDGE_RISE, 1'b0, 1'b0));
		reg_wr(CMP0_ADDR, 8'(c0));
		reg_wr(CMP1_ADDR, 8'(c1));
		reg_wr(MODE_ADDR, 8'hBC);
		reg_wr(CTRL_ADDR, ctrl_val(1'b1, 2'b00, EDGE_RISE, 1'b0, 1'b0));
		n = 0;
		while (cmp_pin !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1 n++;
		end
		hi = 0;
		do begin
			hi++;
			@(posedge clk);
			#1;
		end while (cmp_pin === 1'b1 && hi < 400);
		check_byte(8'(hi), 8'(c1 - c0), "compare high span");
		lo = 0;
		do begin
			lo++;
			@(posedge clk);
			#1;
		end while (cmp_pin === 1'b0 && lo < 400);
		check_byte(8'(lo), 8'(c0 + 1), "compare low span");
		reg_wr(CTRL_ADDR, ctrl_val(1'b0, 2'b00, EDGE_RISE, 1'b0, 1'b0));
		$display("test compare done");
		final_report();
	end
endmodule
`default_nettype wire
